/* File: src/rail_fault_params.svh */
`ifndef RAIL_FAULT_PARAMS_SVH
`define RAIL_FAULT_PARAMS_SVH

`define CLK_PERIOD_PS 25000
`define OV_DELAY_NS 1000
`define UV_DELAY_NS 3000
`define UVLO_DELAY_NS 3000
`define OV_DELAY_CYC ((`OV_DELAY_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define UV_DELAY_CYC ((`UV_DELAY_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define UVLO_DELAY_CYC ((`UVLO_DELAY_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define DLY_CNT_W 8
`define NUM_PHASES 2

`endif

/* File: src/rail_fault_pkg.sv */
package rail_fault_pkg;
  `include "rail_fault_params.svh"

  typedef logic [`DLY_CNT_W-1:0] dly_cnt_t;

  typedef enum logic [2:0] {
    MODE_OFF,
    MODE_RUN,
    MODE_OVP,
    MODE_NVP,
    MODE_UVP,
    MODE_UVLO
  } rail_mode_e;
endpackage : rail_fault_pkg

/* File: src/rail_fault_protection_supervisor.sv */
`timescale 1ns/1ps

`include "rail_fault_params.svh"

// Function
// RQ1 - low vid: ov above fixed level latches
// RQ2 - high vid: ov above reference latches
// RQ3 - ov monitoring only after power-on reset
// RQ4 - ov trip: low-side on, high-side off
// RQ5 - ov trip requests other rail soft shutdown
// RQ6 - ov condition qualified for 1 us
// RQ7 - negative voltage during ov: all off
// RQ8 - voltage back above zero: low-side on
// RQ9 - negative protection only while ov latched
// RQ10 - uv below reference latches
// RQ11 - uv latched: all switches off; code keeps low-side on while ov is also latched
// RQ12 - uv trip requests other rail soft shutdown
// RQ13 - uv condition qualified for 3 us
// RQ14 - supply low during operation enters lockout
// RQ15 - lockout turns every switch enable off
// RQ16 - supply low qualified for 3 us
// RQ17 - latches clear only by reset or re-enable
// RQ18 - deglitch counts, restarts on drop, trips
module rail_fault_protection_supervisor
  import rail_fault_pkg::*;
#(
  parameter int unsigned NUM_PHASES = `NUM_PHASES,
  parameter dly_cnt_t OV_CYC = dly_cnt_t'(`OV_DELAY_CYC),
  parameter dly_cnt_t UV_CYC = dly_cnt_t'(`UV_DELAY_CYC),
  parameter dly_cnt_t UVLO_CYC = dly_cnt_t'(`UVLO_DELAY_CYC)
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic por_done_i,
  input wire logic enable_i,
  input wire logic vid_above_0v9_i,
  input wire logic ov_fixed_cmp_i,
  input wire logic ov_ref_cmp_i,
  input wire logic neg_cmp_i,
  input wire logic uv_cmp_i,
  input wire logic main_supply_low_i,
  input wire logic driver_supply_low_i,
  input wire logic [NUM_PHASES-1:0] phase_active_i,
  input wire logic [NUM_PHASES-1:0] pwm_hs_i,
  input wire logic [NUM_PHASES-1:0] pwm_ls_i,
  output logic [NUM_PHASES-1:0] hs_en_o,
  output logic [NUM_PHASES-1:0] ls_en_o,
  output logic soft_shutdown_req_o,
  output logic ov_latched_o,
  output logic uv_latched_o,
  output logic nv_active_o,
  output logic uvlo_o
);

  typedef struct packed {
    dly_cnt_t ov_cnt;
    dly_cnt_t uv_cnt;
    dly_cnt_t uvlo_cnt;
    logic ov_latch;
    logic uv_latch;
    logic nv_active;
    logic uvlo;
    rail_mode_e mode;
    logic [NUM_PHASES-1:0] hs_en;
    logic [NUM_PHASES-1:0] ls_en;
    logic shutdown_req;
  } state_s;

  localparam state_s STATE_RST = '{
    ov_cnt: '0,
    uv_cnt: '0,
    uvlo_cnt: '0,
    ov_latch: 1'b0,
    uv_latch: 1'b0,
    nv_active: 1'b0,
    uvlo: 1'b0,
    mode: MODE_OFF,
    hs_en: '0,
    ls_en: '0,
    shutdown_req: 1'b0
  };

  logic rst_meta_ff;
  logic rst_sync_ff;
  state_s st_ff;
  state_s nxt_st;
  logic ov_cond;
  logic uv_cond;
  logic uvlo_cond;
  logic ov_trip;
  logic uv_trip;
  logic uvlo_trip;

  // deglitch step: count while asserted, restart on drop, saturate at the length
  function automatic dly_cnt_t dly_step(input dly_cnt_t cnt, input logic cond,
                                        input dly_cnt_t len);
    dly_cnt_t res;
    res = '0;
    if (cond && (cnt < len)) begin
      res = cnt + dly_cnt_t'(1);
    end else if (cond) begin
      res = cnt;
    end
    return res;
  endfunction : dly_step

  // async assert, sync release; only constants enter under reset
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  always_comb begin
    nxt_st = st_ff;

    // threshold chosen by commanded vid; gated until por and while disabled
    ov_cond = por_done_i && enable_i &&
              (vid_above_0v9_i ? ov_ref_cmp_i : ov_fixed_cmp_i); // see RQ1 see RQ2 see RQ3
    uv_cond = por_done_i && enable_i && uv_cmp_i; // see RQ10
    uvlo_cond = por_done_i && (main_supply_low_i || driver_supply_low_i); // see RQ14

    nxt_st.ov_cnt = dly_step(st_ff.ov_cnt, ov_cond, OV_CYC); // see RQ6 see RQ18
    nxt_st.uv_cnt = dly_step(st_ff.uv_cnt, uv_cond, UV_CYC); // see RQ13 see RQ18
    nxt_st.uvlo_cnt = dly_step(st_ff.uvlo_cnt, uvlo_cond, UVLO_CYC); // see RQ16 see RQ18
    ov_trip = ov_cond && (nxt_st.ov_cnt == OV_CYC);
    uv_trip = uv_cond && (nxt_st.uv_cnt == UV_CYC);
    uvlo_trip = uvlo_cond && (nxt_st.uvlo_cnt == UVLO_CYC);

    // latches hold through the fault going away; dropping enable clears them
    if (!enable_i) begin
      nxt_st.ov_latch = 1'b0; // see RQ17
      nxt_st.uv_latch = 1'b0; // see RQ17
    end else begin
      nxt_st.ov_latch = st_ff.ov_latch || ov_trip; // see RQ1 see RQ2
      nxt_st.uv_latch = st_ff.uv_latch || uv_trip; // see RQ10
    end

    // no deglitch on the negative check: the low-side path must open at once
    nxt_st.nv_active = nxt_st.ov_latch && neg_cmp_i; // see RQ7 see RQ8 see RQ9

    if (!uvlo_cond) begin
      nxt_st.uvlo = 1'b0;
    end else if (uvlo_trip) begin
      nxt_st.uvlo = 1'b1; // see RQ14
    end

    // lockout wins since drivers lose supply; ov beats uv to keep the cpu clamped
    if (nxt_st.uvlo) begin
      nxt_st.mode = MODE_UVLO;
    end else if (nxt_st.ov_latch && nxt_st.nv_active) begin
      nxt_st.mode = MODE_NVP;
    end else if (nxt_st.ov_latch) begin
      nxt_st.mode = MODE_OVP;
    end else if (nxt_st.uv_latch) begin
      nxt_st.mode = MODE_UVP;
    end else if (por_done_i && enable_i) begin
      nxt_st.mode = MODE_RUN;
    end else begin
      nxt_st.mode = MODE_OFF;
    end

    case (nxt_st.mode)
      MODE_RUN: begin
        nxt_st.hs_en = pwm_hs_i & phase_active_i;
        nxt_st.ls_en = pwm_ls_i & phase_active_i;
      end
      MODE_OVP: begin
        nxt_st.hs_en = '0; // see RQ4
        nxt_st.ls_en = phase_active_i; // see RQ4 see RQ8
      end
      MODE_NVP: begin
        nxt_st.hs_en = '0; // see RQ7
        nxt_st.ls_en = '0; // see RQ7
      end
      MODE_UVP: begin
        nxt_st.hs_en = '0; // see RQ11
        nxt_st.ls_en = '0; // see RQ11
      end
      MODE_UVLO: begin
        nxt_st.hs_en = '0; // see RQ15
        nxt_st.ls_en = '0; // see RQ15
      end
      default: begin
        nxt_st.hs_en = '0;
        nxt_st.ls_en = '0;
      end
    endcase

    nxt_st.shutdown_req = nxt_st.ov_latch || nxt_st.uv_latch; // see RQ5 see RQ12
  end

  always_ff @(posedge core_clk_i or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      st_ff <= STATE_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign hs_en_o = st_ff.hs_en;
  assign ls_en_o = st_ff.ls_en;
  assign soft_shutdown_req_o = st_ff.shutdown_req;
  assign ov_latched_o = st_ff.ov_latch;
  assign uv_latched_o = st_ff.uv_latch;
  assign nv_active_o = st_ff.nv_active;
  assign uvlo_o = st_ff.uvlo;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_sync_ff);

  sequence ov_armed_s;
    (st_ff.ov_cnt == OV_CYC - dly_cnt_t'(1)) && ov_cond && enable_i;
  endsequence

  sequence uv_armed_s;
    (st_ff.uv_cnt == UV_CYC - dly_cnt_t'(1)) && uv_cond && enable_i;
  endsequence

  sequence uvlo_armed_s;
    (st_ff.uvlo_cnt == UVLO_CYC - dly_cnt_t'(1)) && uvlo_cond;
  endsequence

  sequence ov_rise_s;
    !st_ff.ov_latch ##1 st_ff.ov_latch;
  endsequence

  ov_trip_timely_a: assert property ( // see RQ1
    ov_armed_s |=> st_ff.ov_latch
  ) else $error("ov latch not set after full qualify");

  ov_trip_cause_a: assert property ( // see RQ6
    ov_rise_s |-> $past(st_ff.ov_cnt) == OV_CYC - dly_cnt_t'(1) && $past(ov_cond)
  ) else $error("ov latch set before qualify time");

  ov_threshold_sel_a: assert property ( // see RQ2
    ov_rise_s |-> $past(vid_above_0v9_i) ? $past(ov_ref_cmp_i) : $past(ov_fixed_cmp_i)
  ) else $error("ov latch set without selected comparator");

  ov_por_gate_a: assert property ( // see RQ3
    !por_done_i |=> st_ff.ov_cnt == '0 && !$rose(st_ff.ov_latch)
  ) else $error("ov monitor ran before por");

  ov_clamp_a: assert property ( // see RQ4
    st_ff.ov_latch && !st_ff.nv_active && !st_ff.uvlo
      |-> hs_en_o == '0 && ls_en_o == $past(phase_active_i)
  ) else $error("ov clamp drive wrong");

  shutdown_req_a: assert property ( // see RQ5
    soft_shutdown_req_o == (st_ff.ov_latch || st_ff.uv_latch)
  ) else $error("soft shutdown request mismatch");

  dly_restart_a: assert property ( // see RQ18
    !ov_cond ##1 1'b1 |-> st_ff.ov_cnt == '0
  ) else $error("deglitch did not restart");

  nv_open_a: assert property ( // see RQ7
    st_ff.nv_active |-> hs_en_o == '0 && ls_en_o == '0
  ) else $error("switches on during negative protection");

  nv_release_a: assert property ( // see RQ8
    st_ff.ov_latch && !st_ff.uvlo && $fell(st_ff.nv_active)
      |-> ls_en_o == $past(phase_active_i)
  ) else $error("low side not restored after negative event");

  nv_gated_a: assert property ( // see RQ9
    st_ff.nv_active |-> st_ff.ov_latch && $past(neg_cmp_i)
  ) else $error("negative protection outside ov latch");

  uv_trip_a: assert property ( // see RQ10
    uv_armed_s |=> st_ff.uv_latch
  ) else $error("uv latch not set after full qualify");

  uv_off_a: assert property ( // see RQ11
    st_ff.uv_latch && !st_ff.ov_latch |-> hs_en_o == '0 && ls_en_o == '0
  ) else $error("switches on during uv latch");

  uv_qualify_a: assert property ( // see RQ13
    $rose(st_ff.uv_latch) |-> $past(st_ff.uv_cnt) == UV_CYC - dly_cnt_t'(1)
  ) else $error("uv latch set before qualify time");

  uvlo_trip_a: assert property ( // see RQ16
    uvlo_armed_s |=> st_ff.uvlo
  ) else $error("lockout not entered after qualify");

  uvlo_cause_a: assert property ( // see RQ14
    $rose(st_ff.uvlo) |-> $past(uvlo_cond) && $past(st_ff.uvlo_cnt) == UVLO_CYC - dly_cnt_t'(1)
  ) else $error("lockout without qualified supply low");

  uvlo_off_a: assert property ( // see RQ15
    st_ff.uvlo |-> hs_en_o == '0 && ls_en_o == '0
  ) else $error("switches on during lockout");

  latch_hold_a: assert property ( // see RQ17
    st_ff.ov_latch && enable_i |=> st_ff.ov_latch
  ) else $error("ov latch dropped while enabled");

  uv_hold_a: assert property ( // see RQ17
    st_ff.uv_latch && enable_i |=> st_ff.uv_latch
  ) else $error("uv latch dropped while enabled");

  ov_req_rise_a: assert property ( // see RQ5
    $rose(st_ff.ov_latch) |-> soft_shutdown_req_o
  ) else $error("no shutdown request on ov trip");

  uv_req_rise_a: assert property ( // see RQ12
    $rose(st_ff.uv_latch) |-> soft_shutdown_req_o
  ) else $error("no shutdown request on uv trip");

  // first three edges after release still show the reset drive, so they are skipped
  run_pass_a: assert property ( // see RQ15
    $past(rst_sync_ff) && $past(por_done_i && enable_i) &&
      !st_ff.uvlo && !st_ff.ov_latch && !st_ff.uv_latch
      |-> hs_en_o == $past(pwm_hs_i & phase_active_i) &&
          ls_en_o == $past(pwm_ls_i & phase_active_i)
  ) else $error("run drive does not follow pwm");

  idle_off_a: assert property ( // see RQ17
    !$past(enable_i) |-> !st_ff.ov_latch && !st_ff.uv_latch && hs_en_o == '0 && ls_en_o == '0
  ) else $error("latch or drive left on while disabled");

  uvlo_release_a: assert property ( // see RQ14
    !$past(uvlo_cond) |-> !st_ff.uvlo
  ) else $error("lockout held after supplies recovered");

  uv_restart_a: assert property ( // see RQ18
    !uv_cond ##1 1'b1 |-> st_ff.uv_cnt == '0
  ) else $error("uv deglitch did not restart");

  uvlo_restart_a: assert property ( // see RQ18
    !uvlo_cond ##1 1'b1 |-> st_ff.uvlo_cnt == '0
  ) else $error("lockout deglitch did not restart");

  nv_follow_a: assert property ( // see RQ7
    st_ff.ov_latch && $past(neg_cmp_i) |-> st_ff.nv_active
  ) else $error("negative protection missed");

  dly_bound_a: assert property ( // see RQ18
    st_ff.ov_cnt <= OV_CYC && st_ff.uv_cnt <= UV_CYC && st_ff.uvlo_cnt <= UVLO_CYC
  ) else $error("deglitch count past its length");

endmodule : rail_fault_protection_supervisor

/* File: bench/sense_cmp_model.sv */
`timescale 1ns/1ps
// behavioural sense comparators; the rail reference tracks the commanded vid
module sense_cmp_model (
  input wire logic signed [15:0] sense_mv_i,
  input wire logic signed [15:0] vid_mv_i,
  output logic vid_above_o,
  output logic ov_fixed_o,
  output logic ov_ref_o,
  output logic neg_o,
  output logic uv_o
);
  assign vid_above_o = vid_mv_i > 16'sd900;
  assign ov_fixed_o = sense_mv_i > 16'sd1225;
  assign ov_ref_o = sense_mv_i > vid_mv_i + 16'sd325;
  assign neg_o = sense_mv_i < 16'sd0;
  assign uv_o = sense_mv_i < vid_mv_i - 16'sd500;
endmodule : sense_cmp_model

/* File: bench/rail_fault_protection_supervisor_tb.sv */
`timescale 1ns/1ps
module rail_fault_protection_supervisor_tb;
  import rail_fault_pkg::*;
  // shortened deglitch lengths keep the run small
  localparam int OVC = 3;
  localparam int UVC = 5;
  localparam int LOC = 5;
  logic core_clk_i = 1'b0, rst_n_i = 1'b0, por = 1'b0, en = 1'b1, msl = 1'b0, dsl = 1'b0;
  logic [1:0] act = 2'h3, phs = 2'h0, pls = 2'h0, hs, ls;
  logic ss, ovl, uvl, nva, lo, vab, ovf, ovr, ngc, uvc;
  logic signed [15:0] sense = 16'sd800, vid = 16'sd800;
  int miscompares = 0, total_checks = 0, seed = 52;
  int m_sync = 0, m_ovn = 0, m_uvn = 0, m_lon = 0;
  logic m_ov = 1'b0, m_uv = 1'b0, m_lo = 1'b0, m_nv = 1'b0, m_ss = 1'b0;
  logic [1:0] m_hs = 2'h0, m_ls = 2'h0;

  sense_cmp_model i_cmp (.sense_mv_i(sense), .vid_mv_i(vid), .vid_above_o(vab),
    .ov_fixed_o(ovf), .ov_ref_o(ovr), .neg_o(ngc), .uv_o(uvc));

  rail_fault_protection_supervisor #(.NUM_PHASES(2), .OV_CYC(dly_cnt_t'(OVC)),
    .UV_CYC(dly_cnt_t'(UVC)), .UVLO_CYC(dly_cnt_t'(LOC))) i_dut (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .por_done_i(por), .enable_i(en),
    .vid_above_0v9_i(vab), .ov_fixed_cmp_i(ovf), .ov_ref_cmp_i(ovr), .neg_cmp_i(ngc),
    .uv_cmp_i(uvc), .main_supply_low_i(msl), .driver_supply_low_i(dsl),
    .phase_active_i(act), .pwm_hs_i(phs), .pwm_ls_i(pls), .hs_en_o(hs), .ls_en_o(ls),
    .soft_shutdown_req_o(ss), .ov_latched_o(ovl), .uv_latched_o(uvl),
    .nv_active_o(nva), .uvlo_o(lo));

  initial begin
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  // reference model: state first updates at the third edge after release
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      m_sync = 0;
      {m_ovn, m_uvn, m_lon} = '0;
      {m_ov, m_uv, m_lo, m_nv, m_ss, m_hs, m_ls} = '0;
    end else if (m_sync < 2) begin
      m_sync++;
    end else begin
      m_ovn = (por && en && (vab ? ovr : ovf)) ? m_ovn + 1 : 0;
      m_uvn = (por && en && uvc) ? m_uvn + 1 : 0;
      m_lon = (por && (msl || dsl)) ? m_lon + 1 : 0;
      m_ov = en && (m_ov || m_ovn >= OVC);
      m_uv = en && (m_uv || m_uvn >= UVC);
      m_lo = por && (msl || dsl) && (m_lo || m_lon >= LOC);
      m_nv = m_ov && ngc;
      m_ss = m_ov || m_uv;
      m_hs = (m_lo || m_ov || m_uv || !(por && en)) ? 2'h0 : phs & act;
      m_ls = m_lo ? 2'h0 : m_ov ? (m_nv ? 2'h0 : act) :
        (m_uv || !(por && en)) ? 2'h0 : pls & act;
    end
  end

  task automatic check(input logic [4:0] got, input logic [4:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  always @(negedge core_clk_i) begin
    check({3'h0, hs}, {3'h0, m_hs});
    check({3'h0, ls}, {3'h0, m_ls});
    check({ss, ovl, uvl, nva, lo}, {m_ss, m_ov, m_uv, m_nv, m_lo});
  end

  // random pwm requests every cycle so the run path is really exercised
  task automatic step(input int mv, input int n);
    repeat (n) begin
      @(posedge core_clk_i);
      sense <= 16'(mv);
      phs <= 2'($random(seed));
      pls <= 2'($random(seed));
    end
  endtask : step

  task automatic done(input string name);
    $display("test %s finished at %0t", name, $time);
  endtask : done

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (4) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    step(1300, 8);
    por <= 1'b1;
    step(800, 8);
    done("por gate and run");
    step(1300, OVC - 1);
    step(800, 2);
    step(1300, OVC);
    act <= 2'($random(seed));
    step(800, 3);
    step(-50, 3);
    step(800, 3);
    act <= 2'h3;
    en <= 1'b0;
    step(800, 2);
    en <= 1'b1;
    step(800, 2);
    done("ov fixed and nv");
    vid <= 16'sd1100;
    step(1400, 3);
    step(1500, OVC + 2);
    en <= 1'b0;
    step(1100, 2);
    en <= 1'b1;
    step(-50, UVC - 1);
    step(1100, 2);
    done("ov reference and nv gate");
    step(500, UVC);
    step(1100, 3);
    en <= 1'b0;
    step(1100, 2);
    en <= 1'b1;
    step(1100, 2);
    done("uv");
    msl <= 1'b1;
    step(1100, LOC + 2);
    msl <= 1'b0;
    step(1100, 2);
    dsl <= 1'b1;
    step(1100, LOC - 1);
    dsl <= 1'b0;
    step(1100, 2);
    dsl <= 1'b1;
    step(1100, LOC + 1);
    dsl <= 1'b0;
    step(1100, 2);
    rst_n_i <= 1'b0;
    step(1100, 3);
    rst_n_i <= 1'b1;
    step(1100, 6);
    done("lockout and reset");
    finish_test();
  end

  initial begin
    repeat (2000) @(posedge core_clk_i);
    miscompares++;
    finish_test();
  end
endmodule : rail_fault_protection_supervisor_tb
